// >>> irm_pkg.sv
// Constants, types and helpers shared by the remainder unit files
`default_nettype none
package irm_pkg;
   // Register port offsets
   localparam logic [3:0] ADDR_STATUS = 4'h0;
   localparam logic [3:0] ADDR_INT_STAT = 4'h1;
   localparam logic [3:0] ADDR_INT_MASK = 4'h2;
   localparam logic [3:0] ADDR_FP_SEL = 4'h3;
   localparam logic [3:0] ADDR_FP_DATA = 4'h4;
   // Exception byte bit positions
   localparam int EXC_BRANCH_UNORDERED_FLAG = 7;
   localparam int EXC_SIGNALING_NAN_FLAG = 6;
   localparam int EXC_OPERAND_ERROR_FLAG = 5;
   localparam int EXC_OVERFLOW_FLAG = 4;
   localparam int EXC_UNDERFLOW_FLAG = 3;
   localparam int EXC_DZ = 2;
   localparam int EXC_RESULT_INEXACT_FLAG = 1;
   localparam int EXC_DECIMAL_INPUT_INEXACT_FLAG = 0;
   // Interrupt status bit positions
   localparam int INT_DONE = 0;
   localparam int INT_OPERAND_ERROR_FLAG = 1;
   localparam int INT_ILLEGAL = 2;
   // Values after reset
   localparam logic [2:0] INT_MASK_RST = 3'h0;
   localparam logic [31:0] RDATA_RST = 32'h0000_0000;
   // Source formats
   localparam logic [2:0] FMT_LONG = 3'h0;
   localparam logic [2:0] FMT_SINGLE = 3'h1;
   localparam logic [2:0] FMT_EXT = 3'h2;
   localparam logic [2:0] FMT_PACKED = 3'h3;
   localparam logic [2:0] FMT_WORD = 3'h4;
   localparam logic [2:0] FMT_DOUBLE = 3'h5;
   localparam logic [2:0] FMT_BYTE = 3'h6;
   // Addressing modes
   localparam logic [2:0] EA_DREG = 3'h0;
   localparam logic [2:0] EA_AREG = 3'h1;
   localparam logic [2:0] EA_SPECIAL = 3'h7;
   localparam logic [2:0] EA_REG_IMM = 3'h4;
   // Command encodings
   localparam logic [3:0] CP_LINE = 4'hf;
   localparam logic [8:0] NOP_OP_LOW = 9'h080;
   localparam logic [15:0] NOP_EXT = 16'h0000;
   localparam logic [2:0] OPCLASS_GEN = 3'h0;
   localparam logic [6:0] REM_OPMODE = 7'h25;
   // Extended format numbers
   localparam logic [14:0] EXP_MAX = 15'h7fff;
   localparam logic [14:0] EXP_BIAS = 15'h3fff;
   localparam logic [14:0] SGL_BIAS = 15'h007f;
   localparam logic [14:0] DBL_BIAS = 15'h03ff;
   localparam logic [14:0] INT_EXP = 15'h401e;
   localparam logic [63:0] QNAN_MANT = 64'hc000_0000_0000_0000;

   typedef enum logic [1:0] {ST_IDLE, ST_DIVIDE, ST_ROUND, ST_NORM} irm_state_t;

   // Leading zero count, 64 for zero
   function automatic logic [6:0] irm_lzc64(input logic [63:0] v);
      logic [6:0] n;
      logic found;
      n = 7'h40;
      found = 1'b0;
      for (int i = 63; i >= 0; i--) begin
         if (!found && v[i]) begin
            n = 7'(63 - i);
            found = 1'b1;
         end
      end
      return n;
   endfunction
endpackage
`default_nettype wire

// >>> irm_cmd_decode.sv
// Command word decoder of the remainder unit
`timescale 1ns/1ps
`default_nettype none
module irm_cmd_decode (
   // Command words
   input wire logic [15:0] cmdOp,
   input wire logic [15:0] cmdExt,
   input wire logic [2:0] ownId,
   // Decoded fields
   output logic idMatch,
   output logic isNop,
   output logic isRem,
   output logic fromMem,
   output logic [2:0] srcSpec,
   output logic [2:0] dstReg,
   output logic eaLegal
);
   logic [2:0] eaMode;
   logic [2:0] eaReg;
   logic intFmt;
   assign eaMode = cmdOp[5:3];
   assign eaReg = cmdOp[2:0];
   assign idMatch = cmdOp[15:12] == irm_pkg::CP_LINE && cmdOp[11:9] == ownId;
   assign isNop = cmdOp[8:0] == irm_pkg::NOP_OP_LOW && cmdExt == irm_pkg::NOP_EXT;
   assign isRem = cmdOp[8:6] == irm_pkg::OPCLASS_GEN && !cmdExt[15] && !cmdExt[13]
      && cmdExt[6:0] == irm_pkg::REM_OPMODE;
   assign fromMem = cmdExt[14];
   assign srcSpec = cmdExt[12:10];
   assign dstReg = cmdExt[9:7];
   assign intFmt = srcSpec == irm_pkg::FMT_BYTE || srcSpec == irm_pkg::FMT_WORD
      || srcSpec == irm_pkg::FMT_LONG || srcSpec == irm_pkg::FMT_SINGLE;
   // Addressing mode check, register field ignored for register sources
   always_comb begin
      eaLegal = 1'b1;
      if (fromMem) begin
         case (eaMode)
            irm_pkg::EA_DREG: eaLegal = intFmt;
            irm_pkg::EA_AREG: eaLegal = 1'b0;
            irm_pkg::EA_SPECIAL: eaLegal = eaReg <= irm_pkg::EA_REG_IMM;
            default: eaLegal = 1'b1;
         endcase
         if (srcSpec == 3'h7) begin
            eaLegal = 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// >>> irm_to_extended.sv
// Operand conversion to normalised extended precision
`timescale 1ns/1ps
`default_nettype none
module irm_to_extended (
   // Raw operand
   input wire logic [2:0] fmt,
   input wire logic [79:0] data,
   // Extended result
   output logic sign,
   output logic [14:0] exp,
   output logic [63:0] mant
);
   always_comb begin
      logic [31:0] iv;
      logic [63:0] raw;
      logic [14:0] rawExp;
      logic [6:0] sh;
      logic pass;
      iv = data[31:0];
      raw = 64'h0000_0000_0000_0000;
      rawExp = 15'h0000;
      pass = 1'b0;
      sh = 7'h00;
      sign = 1'b0;
      exp = 15'h0000;
      mant = 64'h0000_0000_0000_0000;
      case (fmt)
         irm_pkg::FMT_LONG, irm_pkg::FMT_WORD, irm_pkg::FMT_BYTE: begin
            if (fmt == irm_pkg::FMT_WORD) begin
               iv = {{16{data[15]}}, data[15:0]};
            end else if (fmt == irm_pkg::FMT_BYTE) begin
               iv = {{24{data[7]}}, data[7:0]};
            end
            sign = iv[31];
            raw = {(iv[31] ? 32'(-iv) : iv), 32'h0000_0000};
            rawExp = irm_pkg::INT_EXP;
         end
         irm_pkg::FMT_SINGLE: begin
            sign = data[31];
            raw = {data[30:23] != 8'h00, data[22:0], 40'h00_0000_0000};
            rawExp = {7'h00, data[30:23]} + irm_pkg::EXP_BIAS - irm_pkg::SGL_BIAS;
            if (data[30:23] == 8'hff) begin
               pass = 1'b1;
               rawExp = irm_pkg::EXP_MAX;
            end else if (data[30:23] == 8'h00) begin
               rawExp = irm_pkg::EXP_BIAS - irm_pkg::SGL_BIAS + 15'h0001;
            end
         end
         irm_pkg::FMT_DOUBLE: begin
            sign = data[63];
            raw = {data[62:52] != 11'h000, data[51:0], 11'h000};
            rawExp = {4'h0, data[62:52]} + irm_pkg::EXP_BIAS - irm_pkg::DBL_BIAS;
            if (data[62:52] == 11'h7ff) begin
               pass = 1'b1;
               rawExp = irm_pkg::EXP_MAX;
            end else if (data[62:52] == 11'h000) begin
               rawExp = irm_pkg::EXP_BIAS - irm_pkg::DBL_BIAS + 15'h0001;
            end
         end
         default: begin
            sign = data[79];
            raw = data[63:0];
            rawExp = data[78:64];
            pass = data[78:64] == irm_pkg::EXP_MAX;
         end
      endcase
      sh = irm_pkg::irm_lzc64(raw);
      if (pass) begin
         exp = rawExp;
         mant = raw;
      end else if (raw != 64'h0000_0000_0000_0000) begin
         exp = rawExp - {8'h00, sh};
         mant = raw << sh;
      end
   end
endmodule
`default_nettype wire

// >>> irm_remainder_unit.sv
// Remainder unit: command decode, remainder datapath, status and registers
`timescale 1ns/1ps
`default_nettype none
module irm_remainder_unit #(
   parameter logic [2:0] OWN_ID = 3'h1
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Command port
   input wire logic cmdValid,
   input wire logic [15:0] cmdOp,
   input wire logic [15:0] cmdExt,
   input wire logic [79:0] srcData,
   input wire logic srcDecInexact,
   output logic cmdBusy,
   output logic cmdDone,
   output logic cmdIllegal,
   output logic excReport,
   // Register port
   input wire logic [3:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata,
   // Interrupt
   output logic irq
);
   typedef struct packed {
      irm_pkg::irm_state_t state;
      logic [7:0] fpSign;
      logic [7:0][14:0] fpExp;
      logic [7:0][63:0] fpMant;
      logic [4:0] fpSel;
      logic [3:0] cc;
      logic [7:0] quot;
      logic [7:0] exc;
      logic [2:0] intStat;
      logic [2:0] intMask;
      logic [2:0] dst;
      logic sD;
      logic [14:0] eS;
      logic [63:0] m;
      logic [65:0] r;
      logic [6:0] q;
      logic [16:0] cnt;
      logic flip;
      logic busy;
      logic done;
      logic illegal;
      logic excRep;
      logic irq;
      logic [31:0] rdata;
   } irm_core_t;

   irm_core_t st_reg;
   irm_core_t st_next;

   logic idMatch;
   logic isNop;
   logic isRem;
   logic fromMem;
   logic [2:0] srcSpec;
   logic [2:0] dstReg;
   logic eaLegal;
   logic sSign;
   logic [14:0] sExp;
   logic [63:0] sMant;
   logic dSign;
   logic [14:0] dExp;
   logic [63:0] dMant;
   logic acc;
   logic remOk;
   logic sZero;
   logic dZero;
   logic sInf;
   logic dInf;
   logic signaling_nan_flag;
   logic dNan;
   logic [16:0] nDiff;

   function automatic logic isInfOf(input logic [14:0] e, input logic [63:0] m);
      return e == irm_pkg::EXP_MAX && m[62:0] == 63'h0;
   endfunction

   function automatic logic isNanOf(input logic [14:0] e, input logic [63:0] m);
      return e == irm_pkg::EXP_MAX && m[62:0] != 63'h0;
   endfunction

   irm_cmd_decode u_decode (
      .cmdOp(cmdOp),
      .cmdExt(cmdExt),
      .ownId(OWN_ID),
      .idMatch(idMatch),
      .isNop(isNop),
      .isRem(isRem),
      .fromMem(fromMem),
      .srcSpec(srcSpec),
      .dstReg(dstReg),
      .eaLegal(eaLegal)
   );

   // Source from memory with its format, or from a floating-point register
   irm_to_extended u_src (
      .fmt(fromMem ? srcSpec : irm_pkg::FMT_EXT),
      .data(fromMem ? srcData : {st_reg.fpSign[srcSpec], st_reg.fpExp[srcSpec],
         st_reg.fpMant[srcSpec]}),
      .sign(sSign),
      .exp(sExp),
      .mant(sMant)
   );

   irm_to_extended u_dst (
      .fmt(irm_pkg::FMT_EXT),
      .data({st_reg.fpSign[dstReg], st_reg.fpExp[dstReg], st_reg.fpMant[dstReg]}),
      .sign(dSign),
      .exp(dExp),
      .mant(dMant)
   );

   assign acc = cmdValid && st_reg.state == irm_pkg::ST_IDLE && idMatch;
   assign remOk = isRem && !isNop && eaLegal;
   assign sZero = !sInf && !signaling_nan_flag && sMant == 64'h0000_0000_0000_0000;
   assign dZero = !dInf && !dNan && dMant == 64'h0000_0000_0000_0000;
   assign sInf = isInfOf(sExp, sMant);
   assign dInf = isInfOf(dExp, dMant);
   assign signaling_nan_flag = isNanOf(sExp, sMant);
   assign dNan = isNanOf(dExp, dMant);
   assign nDiff = {2'b00, dExp} - {2'b00, sExp};

   always_comb begin
      logic [65:0] m2;
      logic [65:0] rr;
      logic [6:0] sh;
      logic [2:0] ev;
      logic [2:0] w1c;
      logic wrRes;
      logic resS;
      logic [14:0] resE;
      logic [63:0] resM;
      logic [2:0] ri;
      m2 = {1'b0, st_reg.m, 1'b0};
      rr = st_reg.r;
      sh = irm_pkg::irm_lzc64(st_reg.r[63:0]);
      ev = 3'h0;
      w1c = 3'h0;
      wrRes = 1'b0;
      resS = 1'b0;
      resE = 15'h0000;
      resM = 64'h0000_0000_0000_0000;
      ri = st_reg.fpSel[4:2];
      st_next = st_reg;
      st_next.done = 1'b0;
      st_next.illegal = 1'b0;
      st_next.rdata = irm_pkg::RDATA_RST;
      // Register reads answer in the next cycle
      if (regRd) begin
         case (regAddr)
            irm_pkg::ADDR_STATUS:
               st_next.rdata = {4'h0, st_reg.cc, st_reg.quot, st_reg.exc, 8'h00};
            irm_pkg::ADDR_INT_STAT: st_next.rdata = {29'h0, st_reg.intStat};
            irm_pkg::ADDR_INT_MASK: st_next.rdata = {29'h0, st_reg.intMask};
            irm_pkg::ADDR_FP_SEL: st_next.rdata = {27'h0, st_reg.fpSel};
            irm_pkg::ADDR_FP_DATA: begin
               case (st_reg.fpSel[1:0])
                  2'h0: st_next.rdata = st_reg.fpMant[ri][31:0];
                  2'h1: st_next.rdata = st_reg.fpMant[ri][63:32];
                  2'h2: st_next.rdata = {16'h0000, st_reg.fpSign[ri], st_reg.fpExp[ri]};
                  default: st_next.rdata = irm_pkg::RDATA_RST;
               endcase
            end
            default: st_next.rdata = irm_pkg::RDATA_RST;
         endcase
      end
      // Register writes
      if (regWr) begin
         case (regAddr)
            irm_pkg::ADDR_INT_STAT: w1c = regWdata[2:0];
            irm_pkg::ADDR_INT_MASK: st_next.intMask = regWdata[2:0];
            irm_pkg::ADDR_FP_SEL: st_next.fpSel = regWdata[4:0];
            irm_pkg::ADDR_FP_DATA: begin
               case (st_reg.fpSel[1:0])
                  2'h0: st_next.fpMant[ri][31:0] = regWdata;
                  2'h1: st_next.fpMant[ri][63:32] = regWdata;
                  2'h2: begin
                     st_next.fpSign[ri] = regWdata[15];
                     st_next.fpExp[ri] = regWdata[14:0];
                  end
                  default: st_next.fpSel = st_reg.fpSel;
               endcase
            end
            default: st_next.fpSel = st_reg.fpSel;
         endcase
      end
      case (st_reg.state)
         irm_pkg::ST_IDLE: begin
            if (acc && isNop) begin
               st_next.done = 1'b1;
               st_next.excRep = st_reg.exc != 8'h00;
               ev[irm_pkg::INT_DONE] = 1'b1;
            end else if (acc && !remOk) begin
               st_next.illegal = 1'b1;
               ev[irm_pkg::INT_ILLEGAL] = 1'b1;
            end else if (acc) begin
               st_next.dst = dstReg;
               st_next.sD = dSign;
               st_next.eS = sExp;
               st_next.m = sMant;
               st_next.r = {2'b00, dMant};
               st_next.q = 7'h00;
               st_next.flip = 1'b0;
               st_next.excRep = 1'b0;
               st_next.quot = {dSign ^ sSign, 7'h00};
               st_next.exc = 8'h00;
               st_next.exc[irm_pkg::EXC_DECIMAL_INPUT_INEXACT_FLAG] = fromMem && srcSpec == irm_pkg::FMT_PACKED
                  && srcDecInexact;
               wrRes = 1'b1;
               resS = dSign;
               resE = dExp;
               resM = dMant;
               if (dNan || signaling_nan_flag) begin
                  st_next.exc[irm_pkg::EXC_SIGNALING_NAN_FLAG] = dNan ? !dMant[62] : !sMant[62];
                  resS = dNan ? dSign : sSign;
                  resM = (dNan ? dMant : sMant) | irm_pkg::QNAN_MANT;
                  resE = irm_pkg::EXP_MAX;
               end else if (sZero || dInf) begin
                  st_next.exc[irm_pkg::EXC_OPERAND_ERROR_FLAG] = 1'b1;
                  ev[irm_pkg::INT_OPERAND_ERROR_FLAG] = 1'b1;
                  resS = 1'b0;
                  resE = irm_pkg::EXP_MAX;
                  resM = irm_pkg::QNAN_MANT;
               end else if (dZero) begin
                  resE = 15'h0000;
                  resM = 64'h0000_0000_0000_0000;
               end else if (!sInf && !nDiff[16]) begin
                  wrRes = 1'b0;
                  st_next.cnt = nDiff + 17'h2;
                  st_next.state = irm_pkg::ST_DIVIDE;
               end else if (!sInf && nDiff == 17'h1ffff) begin
                  wrRes = 1'b0;
                  st_next.cnt = 17'h1;
                  st_next.state = irm_pkg::ST_DIVIDE;
               end
               // Infinite source or tiny destination keep the destination
            end
         end
         irm_pkg::ST_DIVIDE: begin
            if (st_reg.r >= m2) begin
               rr = st_reg.r - m2;
               st_next.q = {st_reg.q[5:0], 1'b1};
            end else begin
               st_next.q = {st_reg.q[5:0], 1'b0};
            end
            st_next.cnt = st_reg.cnt - 17'h1;
            if (st_reg.cnt == 17'h1) begin
               st_next.r = rr;
               st_next.state = irm_pkg::ST_ROUND;
            end else begin
               st_next.r = {rr[64:0], 1'b0};
            end
         end
         irm_pkg::ST_ROUND: begin
            // Above half, or exactly half with odd quotient, rounds up
            if (st_reg.r > {2'b00, st_reg.m} || (st_reg.r == {2'b00, st_reg.m} && st_reg.q[0])) begin
               st_next.r = m2 - st_reg.r;
               st_next.q = st_reg.q + 7'h01;
               st_next.flip = 1'b1;
            end
            st_next.state = irm_pkg::ST_NORM;
         end
         irm_pkg::ST_NORM: begin
            wrRes = 1'b1;
            st_next.quot[6:0] = st_reg.q;
            resS = st_reg.sD ^ st_reg.flip;
            if (st_reg.r[63:0] == 64'h0000_0000_0000_0000) begin
               resS = st_reg.sD;
            end else if ({8'h00, sh} >= st_reg.eS) begin
               st_next.exc[irm_pkg::EXC_UNDERFLOW_FLAG] = 1'b1;
               resE = 15'h0000;
               resM = st_reg.r[63:0] << (st_reg.eS - 15'h0001);
            end else begin
               resE = st_reg.eS - 15'h0001 - {8'h00, sh};
               resM = st_reg.r[63:0] << sh;
            end
            st_next.state = irm_pkg::ST_IDLE;
         end
         default: st_next.state = irm_pkg::ST_IDLE;
      endcase
      // Result write back and condition codes
      if (wrRes) begin
         st_next.fpSign[st_next.dst] = resS;
         st_next.fpExp[st_next.dst] = resE;
         st_next.fpMant[st_next.dst] = resM;
         st_next.cc = {resS, resE != irm_pkg::EXP_MAX && resM == 64'h0000_0000_0000_0000,
            isInfOf(resE, resM), isNanOf(resE, resM)};
         st_next.done = 1'b1;
         ev[irm_pkg::INT_DONE] = 1'b1;
      end
      // New events win over a clearing write
      st_next.intStat = (st_reg.intStat & ~w1c) | ev;
      st_next.irq = (st_next.intStat & st_next.intMask) != 3'h0;
      st_next.busy = st_next.state != irm_pkg::ST_IDLE;
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign cmdBusy = st_reg.busy;
   assign cmdDone = st_reg.done;
   assign cmdIllegal = st_reg.illegal;
   assign excReport = st_reg.excRep;
   assign regRdata = st_reg.rdata;
   assign irq = st_reg.irq;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   AST_NOP_DONE: assert property (acc && isNop |=> cmdDone && !cmdBusy)
      else $error("no-operation did not complete");
   AST_REM_START: assert property (acc && remOk |=> cmdDone || cmdBusy)
      else $error("remainder not started");
   AST_QSIGN: assert property (acc && remOk |=> st_reg.quot[7] == $past(dSign ^ sSign))
      else $error("quotient sign wrong");
   AST_QBYTE: assert property (st_reg.state == irm_pkg::ST_NORM |=>
      st_reg.quot[6:0] == $past(st_reg.q) && cmdDone)
      else $error("quotient bits not loaded");
   AST_OPERAND_ERROR_FLAG: assert property (acc && remOk && (sZero || dInf) && !dNan && !signaling_nan_flag
      |=> st_reg.exc[irm_pkg::EXC_OPERAND_ERROR_FLAG] && cmdDone && st_reg.intStat[irm_pkg::INT_OPERAND_ERROR_FLAG])
      else $error("operand error missing");
   AST_NO_OPERAND_ERROR_FLAG: assert property (acc && remOk && !sZero && !dInf
      |=> !st_reg.exc[irm_pkg::EXC_OPERAND_ERROR_FLAG])
      else $error("operand error not cleared");
   AST_DECIMAL_INPUT_INEXACT_FLAG: assert property (acc && remOk && !(fromMem && srcSpec == irm_pkg::FMT_PACKED)
      |=> !st_reg.exc[irm_pkg::EXC_DECIMAL_INPUT_INEXACT_FLAG])
      else $error("decimal inexact set for non packed source");
   AST_CLEARED: assert property (acc && remOk |=> st_reg.exc[irm_pkg::EXC_BRANCH_UNORDERED_FLAG] == 1'b0
      && !st_reg.exc[irm_pkg::EXC_OVERFLOW_FLAG] && !st_reg.exc[irm_pkg::EXC_DZ]
      && !st_reg.exc[irm_pkg::EXC_RESULT_INEXACT_FLAG])
      else $error("exception bits not cleared");
   AST_FOREIGN_ID: assert property (cmdValid && !cmdBusy && !idMatch
      |=> !cmdDone && !cmdIllegal && !cmdBusy)
      else $error("foreign command acted on");
   AST_AREG: assert property (acc && isRem && fromMem && cmdOp[5:3] == irm_pkg::EA_AREG
      |=> cmdIllegal)
      else $error("address register direct accepted");
   AST_ZERO_DST: assert property (acc && remOk && dZero && !sZero && !signaling_nan_flag
      |=> st_reg.fpMant[st_reg.dst] == 64'h0000_0000_0000_0000
      && st_reg.fpSign[st_reg.dst] == $past(dSign))
      else $error("zero destination result wrong");
   AST_INF_SRC: assert property (acc && remOk && sInf && !dInf && !dZero && !dNan
      |=> st_reg.fpMant[st_reg.dst] == $past(dMant))
      else $error("infinite source did not keep destination");
endmodule
`default_nettype wire

// >>> irm_host_model.sv
// Main processor model that issues commands to the unit
`timescale 1ns/1ps
`default_nettype none
module irm_host_model (
   // Clock
   input wire logic mclk,
   // Command port
   output logic cmdValid,
   output logic [15:0] cmdOp,
   output logic [15:0] cmdExt,
   output logic [79:0] srcData,
   output logic srcDecInexact,
   // Answers
   input wire logic cmdDone,
   input wire logic cmdIllegal
);
   initial begin
      cmdValid = 1'b0;
      cmdOp = 16'h0000;
      cmdExt = 16'h0000;
      srcData = 80'h0;
      srcDecInexact = 1'b0;
   end
   // One command, then wait for done or illegal
   task automatic issue(input logic [15:0] op, input logic [15:0] ext,
      input logic [79:0] data, input logic dec, input int lim, output int got);
      got = 0;
      @(posedge mclk);
      cmdValid <= 1'b1;
      cmdOp <= op;
      cmdExt <= ext;
      srcData <= data;
      srcDecInexact <= dec;
      @(posedge mclk);
      cmdValid <= 1'b0;
      srcData <= ~data;
      for (int i = 0; i < lim && got == 0; i++) begin
         #1;
         if (cmdDone === 1'b1)
            got = 1;
         else if (cmdIllegal === 1'b1)
            got = 2;
         else
            @(posedge mclk);
      end
   endtask
endmodule
`default_nettype wire

// >>> testbench.sv
// Testbench of the remainder unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic cmdValid, srcDecInexact, cmdBusy, cmdDone, cmdIllegal, excReport, irq;
   logic [15:0] cmdOp, cmdExt;
   logic [79:0] srcData;
   logic [3:0] regAddr = 4'h0;
   logic [31:0] regWdata = 32'h0000_0000;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [31:0] regRdata;
   int bad_count = 0;
   int check_count = 0;
   always #12.5 mclk = ~mclk;
   irm_remainder_unit dut_u (.mclk(mclk), .rst(rst), .cmdValid(cmdValid), .cmdOp(cmdOp),
      .cmdExt(cmdExt), .srcData(srcData), .srcDecInexact(srcDecInexact), .cmdBusy(cmdBusy),
      .cmdDone(cmdDone), .cmdIllegal(cmdIllegal), .excReport(excReport), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq));
   irm_host_model hm (.mclk(mclk), .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdExt(cmdExt),
      .srcData(srcData), .srcDecInexact(srcDecInexact), .cmdDone(cmdDone),
      .cmdIllegal(cmdIllegal));
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic ok, input string m);
      check_count++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge mclk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] k, input logic [31:0] w,
      input string m);
      @(posedge mclk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge mclk);
      regRd <= 1'b0;
      #1;
      chk((regRdata & k) === w, m);
   endtask
   task automatic fw(input logic [31:0] s, input logic [31:0] d);
      wr(irm_pkg::ADDR_FP_SEL, s);
      wr(irm_pkg::ADDR_FP_DATA, d);
   endtask
   task automatic fr(input logic [31:0] s, input logic [31:0] w, input string m);
      wr(irm_pkg::ADDR_FP_SEL, s);
      rd(irm_pkg::ADDR_FP_DATA, 32'hffff_ffff, w, m);
   endtask
   task automatic run(input logic [15:0] op, input logic [15:0] ext, input logic [79:0] d,
      input logic dec, input int want);
      int got;
      hm.issue(op, ext, d, dec, 40, got);
      chk(got == want, "command answer");
      if (got != want)
         finish_test();
   endtask
   task automatic t_rem();
      rd(irm_pkg::ADDR_STATUS, 32'hffff_ffff, 32'h0000_0000, "status reset");
      fw(32'h0000_0002, 32'h0000_4001);
      fw(32'h0000_0001, 32'he000_0000);
      fw(32'h0000_0006, 32'h0000_4000);
      fw(32'h0000_0005, 32'h8000_0000);
      run(16'hf200, 16'h0425, 80'h0, 1'b1, 1);
      rd(irm_pkg::ADDR_STATUS, 32'h00ff_ff00, 32'h0004_0000, "quotient");
      fr(32'h0000_0002, 32'h0000_bfff, "sign exp");
      fr(32'h0000_0001, 32'h8000_0000, "mantissa");
   endtask
   task automatic t_zero_src();
      run(16'hf200, 16'h0825, 80'h0, 1'b0, 1);
      rd(irm_pkg::ADDR_STATUS, 32'h0000_ff00, 32'h0000_2000, "operand_error_flag");
      fr(32'h0000_0002, 32'h0000_7fff, "nan");
      chk(irq === 1'b0, "masked irq");
      wr(irm_pkg::ADDR_INT_MASK, 32'h0000_0002);
      rd(irm_pkg::ADDR_INT_STAT, 32'h0000_0002, 32'h0000_0002, "int stat");
      chk(irq === 1'b1, "irq");
      wr(irm_pkg::ADDR_INT_STAT, 32'h0000_0002);
      repeat (2) @(posedge mclk);
      #1;
      chk(irq === 1'b0, "irq clear");
   endtask
   task automatic t_nop_other();
      int got;
      run(16'hf280, 16'h0000, 80'h0, 1'b0, 1);
      chk(excReport === 1'b1, "pending report");
      hm.issue(16'hf400, 16'h0425, 80'h0, 1'b0, 5, got);
      chk(got == 0 && cmdBusy === 1'b0, "other id");
   endtask
   task automatic t_packed();
      fw(32'h0000_000e, 32'h0000_8000);
      run(16'hf210, 16'h4da5, 80'h4000_8000_0000_0000_0000, 1'b1, 1);
      rd(irm_pkg::ADDR_STATUS, 32'h00ff_ff00, 32'h0080_0100, "packed");
      fr(32'h0000_000e, 32'h0000_8000, "signed zero");
      chk(excReport === 1'b0, "report cleared");
      run(16'hf200, 16'h4825, 80'h0, 1'b0, 2);
      run(16'hf208, 16'h4425, 80'h0, 1'b0, 2);
      rd(4'hf, 32'hffff_ffff, 32'h0000_0000, "unmapped");
   endtask
   task automatic t_inf_src();
      run(16'hf210, 16'h44a5, 80'h0000_0000_0000_7f80_0000, 1'b0, 1);
      rd(irm_pkg::ADDR_STATUS, 32'h00ff_ff00, 32'h0000_0000, "inf src status");
      fr(32'h0000_0006, 32'h0000_4000, "inf src keeps exp");
      fr(32'h0000_0005, 32'h8000_0000, "inf src keeps mant");
   endtask
   initial begin
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      t_rem();
      t_zero_src();
      t_nop_other();
      t_packed();
      t_inf_src();
      finish_test();
   end
endmodule
`default_nettype wire
